// ==== rtl/gating_fault_supervisor_map.vh ====
/*
 * constants for the gating fault supervisor: apb register offsets, field
 * positions, reset values and trip limits.
 * assumes a 32-bit apb bus with word-aligned byte addresses.
 */
`ifndef GATING_FAULT_SUPERVISOR_MAP_VH
`define GATING_FAULT_SUPERVISOR_MAP_VH

// register byte offsets
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_MASK          8'h08
`define REG_SAFE_SEL      8'h0C
`define REG_LIVE          8'h10
`define REG_LIMITS        8'h14

// ctrl fields
`define CTRL_DECODE_BIT   0
`define CTRL_ACK_BIT      1

// fault cause positions
`define F_CURRENT         0
`define F_VOLTAGE         1
`define F_TEMP1           2
`define F_TEMP2           3
`define F_SUPPLY_LOW      4
`define F_SUPPLY_HIGH     5
`define NUM_FAULTS        6

// reset values
`define CTRL_RST          32'h00000000
`define MASK_RST          6'h00
`define SAFE_SEL_RST      6'h00

// safe switching patterns (gate bits: a_hi, a_lo, b_hi, b_lo)
`define GATE_BLOCKED      4'h0
`define GATE_SHORT        4'h5

// default trip limits, in amperes, volts, degrees and decivolts
`define LIM_CURRENT_A     8'h19
`define LIM_BUS_V         12'h1A4
`define LIM_TEMP_C        8'h5A
`define LIM_SUPPLY_LO_DV  8'h2D
`define LIM_SUPPLY_HI_DV  8'h37

`endif

// ==== rtl/gate_decoder.v ====
/*
 * gate decoder: turns the four received optical commands into the four
 * switch gate commands, either passed straight or decoded from a state code.
 * assumes the commands are synchronous to the clock of the caller.
 */
module gate_decoder (
    input  wire       decode_en,   // 1 = inputs carry an encoded state
    input  wire [3:0] opt_in,      // received optical commands
    output reg  [3:0] gate_cmd     // per-switch commands
);

    always @*
    begin
        if (!decode_en)
            gate_cmd = opt_in;                          // [R1] [R2]
        else
        begin
            // low two bits pick leg states; complementary legs avoid shoot-through
            case (opt_in[1:0])
                2'h0:    gate_cmd = 4'h5;
                2'h1:    gate_cmd = 4'h6;               // [R2]
                2'h2:    gate_cmd = 4'h9;
                2'h3:    gate_cmd = 4'hA;
                default: gate_cmd = 4'h0;
            endcase
            if (opt_in[3])
                gate_cmd = 4'h0;                        // code bit 3 blocks all
        end
    end

endmodule

// ==== rtl/gating_fault_supervisor.v ====
/*
 * gating fault supervisor: forwards optical gating commands to the gate
 * drivers, latches faults from the fast and slow supervisors, forces a safe
 * switching state and drives the active-low global error line.
 * assumes supervisor flags and the acknowledge button are already
 * synchronous and debounced, and apb runs on core_clk.
 */
// Design decisions made here: the APB register port and the register addresses.
//
// Overview of operation
// R1 - default: each optical input drives its gate
// R2 - gate commands from fibres, optional decoding
// R3 - fault forces blocked or short state, per cause
// R4 - fault flags built from supervisor indications
// R5 - fast supervisor flags current and voltage overvalue
// R6 - slow supervisor flags temperature and supply limits
// R7 - trip at 25 A, 420 V, 90 C
// R8 - supply fault below 4.5 V or above 5.5 V
// R9 - global error high normally, low on fault
// R10 - fault latched until button acknowledge
// R11 - global error relayed to master controller
// R12 - safe state persists until acknowledge
`include "gating_fault_supervisor_map.vh"

module gating_fault_supervisor #(
    parameter NUM_GATES = 4
) (
    input  wire        core_clk,         // 125 mhz clock
    input  wire        rst,              // async reset, active high
    input  wire [3:0]  opt_gate_in,      // optical gating inputs
    input  wire        fast_current_ov,  // fast_supervisor current flag
    input  wire        fast_voltage_ov,  // fast_supervisor bus voltage flag
    input  wire        slow_temp1_ov,    // slow_supervisor heatsink 1 flag
    input  wire        slow_temp2_ov,    // slow_supervisor heatsink 2 flag
    input  wire        slow_supply_low,  // slow_supervisor 5 v under limit
    input  wire        slow_supply_high, // slow_supervisor 5 v over limit
    input  wire        ack_button,       // acknowledge button, active high
    input  wire        psel,             // apb select
    input  wire        penable,          // apb enable
    input  wire        pwrite,           // apb write
    input  wire [7:0]  paddr,            // apb byte address
    input  wire [31:0] pwdata,           // apb write data
    output reg  [31:0] prdata,           // apb read data
    output reg         pready,           // apb ready
    output reg         pslverr,          // apb error on unmapped address
    output reg  [3:0]  gate_out,         // gate driver commands
    output reg         global_err_n,     // global error, active low
    output reg         mezz_err_n,       // error relayed to master via mezzanine
    output reg         irq               // level interrupt
);

    localparam NF = `NUM_FAULTS;

    // trip limits as software reads them back; the supervisors do the comparing
    localparam [7:0]  LIM_CUR     = `LIM_CURRENT_A;
    localparam [11:0] LIM_BUS     = `LIM_BUS_V;
    localparam [7:0]  LIM_TMP     = `LIM_TEMP_C;
    localparam [7:0]  LIM_SHI     = `LIM_SUPPLY_HI_DV;
    // the bus limit keeps only its low byte, the word has no room for more
    localparam [31:0] LIMITS_WORD = {LIM_SHI, LIM_TMP, LIM_BUS[7:0], LIM_CUR};

    ////////////////////////////////////////////////////////////////////////
    // register map, one aligned word each
    //   ctrl     : bit 0 decode enable, bit 1 acknowledge (reads back 0)
    //   status   : sticky causes, write one to clear, a live cause wins
    //   mask     : status bits let through to irq
    //   safe_sel : per cause, 1 asks for the short state, 0 for blocking
    //   live     : raw flags in [11:6] above the fault latch in [5:0]
    //   limits   : trip limits, read only
    // cause bits: current, bus voltage, heatsink 1, heatsink 2,
    // supply low, supply high

    ////////////////////////////////////////////////////////////////////////
    // fault inputs

    wire [NF-1:0] fault_in;
    assign fault_in[`F_CURRENT]     = fast_current_ov;    // [R5] [R7]
    assign fault_in[`F_VOLTAGE]     = fast_voltage_ov;    // [R5] [R7]
    assign fault_in[`F_TEMP1]       = slow_temp1_ov;      // [R6] [R7]
    assign fault_in[`F_TEMP2]       = slow_temp2_ov;      // [R6] [R7]
    assign fault_in[`F_SUPPLY_LOW]  = slow_supply_low;    // [R8]
    assign fault_in[`F_SUPPLY_HIGH] = slow_supply_high;   // [R8]

    reg  [NF-1:0] fault_latch_r;
    reg  [NF-1:0] status_r;
    reg  [NF-1:0] mask_r;
    reg  [NF-1:0] safe_sel_r;
    reg           decode_en_r;
    reg           sw_ack_r;
    reg           ack_prev_r;

    // the button acts on its rising edge, so a held button clears only once
    wire          ack_btn_rise = ack_button & ~ack_prev_r;
    wire          ack_any      = ack_btn_rise | sw_ack_r;

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    wire       apb_acc = psel & penable;
    wire       apb_wr  = apb_acc & pwrite & pready;
    wire       mapped  = (paddr == `REG_CTRL) | (paddr == `REG_STATUS) |
                         (paddr == `REG_MASK) | (paddr == `REG_SAFE_SEL) |
                         (paddr == `REG_LIVE) | (paddr == `REG_LIMITS);
    // read data is picked in the first access cycle and stands with pready
    wire       rd_sample = apb_acc & ~pready & ~pwrite;

    // one strobe per writable register, high in the cycle the write lands
    wire       wr_ctrl     = apb_wr & (paddr == `REG_CTRL);
    wire       wr_status   = apb_wr & (paddr == `REG_STATUS);
    wire       wr_mask     = apb_wr & (paddr == `REG_MASK);
    wire       wr_safe_sel = apb_wr & (paddr == `REG_SAFE_SEL);

    // one wait state: setup, access (pready low), access (pready high)
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pready <= 1'b0;
        else
            pready <= apb_acc & ~pready;
    end

    ////////////////////////////////////////////////////////////////////////
    // fault latch, per cause; input that is still active wins over acknowledge

    genvar i;
    generate
        for (i = 0; i < NF; i = i + 1)
        begin : g_fault
            always @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    fault_latch_r[i] <= 1'b0;
                else if (fault_in[i])
                    fault_latch_r[i] <= 1'b1;                  // [R4] [R10]
                else if (ack_any)
                    fault_latch_r[i] <= 1'b0;                  // [R10] [R12]
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // status bits for software: sticky, write one to clear, a live cause wins

    generate
        for (i = 0; i < NF; i = i + 1)
        begin : g_status
            always @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    status_r[i] <= 1'b0;
                else if (fault_in[i])
                    status_r[i] <= 1'b1;                       // [R4]
                else if (wr_status && pwdata[i])
                    status_r[i] <= 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // acknowledge

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_prev_r <= 1'b0;
            sw_ack_r   <= 1'b0;
        end
        else
        begin
            ack_prev_r <= ack_button;
            // the write lands at the pready edge, so its acknowledge acts a cycle later
            sw_ack_r   <= wr_ctrl & pwdata[`CTRL_ACK_BIT];          // [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            mask_r <= `MASK_RST;
        else if (wr_mask)
            mask_r <= pwdata[NF-1:0];
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            safe_sel_r <= `SAFE_SEL_RST;
        else if (wr_safe_sel)
            safe_sel_r <= pwdata[NF-1:0];
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            decode_en_r <= 1'b0;
        else if (wr_ctrl)
            decode_en_r <= pwdata[`CTRL_DECODE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    reg  [31:0] rdata_nxt;

    always @*
    begin
        case (paddr)
            `REG_CTRL:     rdata_nxt = {31'h0, decode_en_r};
            `REG_STATUS:   rdata_nxt = {26'h0, status_r};
            `REG_MASK:     rdata_nxt = {26'h0, mask_r};
            `REG_SAFE_SEL: rdata_nxt = {26'h0, safe_sel_r};
            `REG_LIVE:     rdata_nxt = {20'h0, fault_in, fault_latch_r};
            `REG_LIMITS:   rdata_nxt = LIMITS_WORD;
            default:       rdata_nxt = 32'h0;
        endcase
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            // zero outside a read so stale data never lingers on the bus
            prdata  <= rd_sample ? rdata_nxt : 32'h00000000;
            pslverr <= apb_acc & ~pready & ~mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gate path

    wire [3:0] gate_cmd;

    gate_decoder u_dec (
        .decode_en (decode_en_r),
        .opt_in    (opt_gate_in),
        .gate_cmd  (gate_cmd)
    );

    ////////////////////////////////////////////////////////////////////////
    // safe state

    // fault seen the same cycle it arrives so the override is not a cycle late
    wire [NF-1:0] active_fault = fault_latch_r | fault_in;
    wire          any_fault    = |active_fault;

    // a cause that asks for blocking overrides any that ask for the short
    // state; blocking is the safer of the two when causes disagree
    wire [NF-1:0] block_req;
    generate
        for (i = 0; i < NF; i = i + 1)
        begin : g_safe
            assign block_req[i] = active_fault[i] & ~safe_sel_r[i];     // [R3]
        end
    endgenerate
    wire          want_short   = ~|block_req;

    reg  [3:0]    gate_nxt;

    always @*
    begin
        if (!any_fault)
            gate_nxt = gate_cmd;                                        // [R1] [R2]
        else if (want_short)
            gate_nxt = `GATE_SHORT;                                     // [R3] [R12]
        else
            gate_nxt = `GATE_BLOCKED;                                   // [R3] [R12]
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            gate_out <= `GATE_BLOCKED;
        else
            gate_out <= gate_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // error lines and interrupt

    wire          irq_nxt      = |(status_r & mask_r);

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            global_err_n <= 1'b1;
            mezz_err_n   <= 1'b1;
            irq          <= 1'b0;
        end
        else
        begin
            global_err_n <= ~any_fault;                               // [R9]
            // a separate copy so the relay can be routed apart from the local line
            mezz_err_n   <= ~any_fault;                               // [R11]
            irq          <= irq_nxt;
        end
    end

endmodule

// ==== sim/remote_ctrl.sv ====
/* far-side model: the remote controller sending gating over the fibres
   and the operator pressing acknowledge. assumes the shared core clock. */
module remote_ctrl (
    input  logic       core_clk,    // shared clock
    output logic [3:0] opt_gate_in, // gating over the fibres
    output logic       ack_button   // acknowledge button
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        opt_gate_in = 4'h0;
        ack_button = 1'b0;
    end
    task send(input logic [3:0] c);
        @(posedge core_clk);
        opt_gate_in <= c;
    endtask
    // one-cycle press; the block acts on the rising edge only
    task press();
        @(posedge core_clk);
        ack_button <= 1'b1;
        @(posedge core_clk);
        ack_button <= 1'b0;
    endtask
endmodule

// ==== sim/gating_fault_supervisor_properties.sv ====
/* port checker for the gating fault supervisor.
   assumes one clock domain; bound below. */
`include "gating_fault_supervisor_map.vh"
module gfs_checker (
    input logic       core_clk,         // clock
    input logic       rst,              // async reset
    input logic       fast_current_ov,  // flag
    input logic       fast_voltage_ov,  // flag
    input logic       slow_temp1_ov,    // flag
    input logic       slow_temp2_ov,    // flag
    input logic       slow_supply_low,  // flag
    input logic       slow_supply_high, // flag
    input logic       ack_button,       // button
    input logic       psel,             // apb
    input logic       penable,          // apb
    input logic       pready,           // apb
    input logic       pslverr,          // apb
    input logic [3:0] gate_out,         // gates
    input logic       global_err_n,     // error
    input logic       mezz_err_n        // relay
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire [5:0] flg = {slow_supply_high, slow_supply_low, slow_temp2_ov, slow_temp1_ov,
                      fast_voltage_ov, fast_current_ov};
    sequence s_trip; |flg; endsequence
    sequence s_safe; gate_out == `GATE_BLOCKED || gate_out == `GATE_SHORT; endsequence
    property p_trip; s_trip |=> s_safe and !global_err_n; endproperty
    a_trip: assert property (p_trip)
        else $error("no safe state after fault");
    property p_safe; !global_err_n |-> s_safe; endproperty
    a_safe: assert property (p_safe)
        else $error("gates not safe in fault");
    property p_relay; mezz_err_n == global_err_n; endproperty
    a_relay: assert property (p_relay)
        else $error("relay differs");
    // register acks land a few cycles late, so quiet bus periods only
    property p_latch; !global_err_n && !ack_button && !$past(ack_button) && !$past(ack_button, 2)
        && !psel && !$past(psel) && !$past(psel, 2) && !$past(psel, 3) |=> !global_err_n;
    endproperty
    a_latch: assert property (p_latch)
        else $error("fault cleared without ack");
    property p_clear; $rose(global_err_n) |-> $past(flg) == 6'h00; endproperty
    a_clear: assert property (p_clear)
        else $error("cleared with flag high");
    property p_quiet; $past(global_err_n) && $past(flg) == 6'h00 |-> global_err_n; endproperty
    a_quiet: assert property (p_quiet)
        else $error("error without fault");
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait)
        else $error("ready late");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once)
        else $error("ready too long");
    property p_serr; pslverr |-> pready; endproperty
    a_serr: assert property (p_serr)
        else $error("error without ready");
endmodule
bind gating_fault_supervisor gfs_checker chk (.core_clk, .rst, .fast_current_ov,
    .fast_voltage_ov, .slow_temp1_ov, .slow_temp2_ov, .slow_supply_low, .slow_supply_high,
    .ack_button, .psel, .penable, .pready, .pslverr, .gate_out, .global_err_n, .mezz_err_n);

// ==== sim/test_gating_fault_supervisor.sv ====
/* self-checking bench for the gating fault supervisor.
   assumes the map header on the include path and the remote controller model. */
`include "gating_fault_supervisor_map.vh"
module test_gating_fault_supervisor;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [39:0] DTAB = 40'h0516293A80;
    localparam logic [5:0]  SEL  = 6'h15;
    logic        core_clk, pready, pslverr, gerr_n, merr_n, irq, ack, serr;
    logic        rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [5:0]  flg = 6'h00;
    logic [3:0]  opt, gate;
    int          errors = 0, n_compared = 0, cyc = 0;
    gating_fault_supervisor uut (.core_clk, .rst, .opt_gate_in(opt),
        .fast_current_ov(flg[0]), .fast_voltage_ov(flg[1]), .slow_temp1_ov(flg[2]),
        .slow_temp2_ov(flg[3]), .slow_supply_low(flg[4]), .slow_supply_high(flg[5]),
        .ack_button(ack), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .gate_out(gate), .global_err_n(gerr_n), .mezz_err_n(merr_n), .irq);
    remote_ctrl far (.core_clk, .opt_gate_in(opt), .ack_button(ack));
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            errors++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task results();
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task t_pass();
        for (int i = 0; i < 16; i++)
        begin
            far.send(i[3:0]);
            repeat (2) @(posedge core_clk);
            chk(gate, i[3:0]);
        end
        chk(gerr_n, 1'b1);
    endtask
    task t_decode();
        apb(1'b1, `REG_CTRL, 32'h00000001);
        for (int k = 0; k < 5; k++)
        begin
            far.send(DTAB[8*k+4 +: 4]);
            repeat (2) @(posedge core_clk);
            chk(gate, DTAB[8*k +: 4]);
        end
        apb(1'b1, `REG_CTRL, 32'h00000000);
    endtask
    task t_fault();
        apb(1'b1, `REG_SAFE_SEL, {26'h0, SEL});
        far.send(4'hF);
        for (int i = 0; i < `NUM_FAULTS; i++)
        begin
            flg <= 6'h01 << i;
            repeat (2) @(posedge core_clk);
            chk(gate, SEL[i] ? `GATE_SHORT : `GATE_BLOCKED);
            chk(merr_n, 1'b0);
            flg <= 6'h00;
            repeat (3) @(posedge core_clk);
            chk(gerr_n, 1'b0);
            far.press();
            repeat (4) @(posedge core_clk);
            chk(gate, 4'hF);
        end
    endtask
    task t_refuse();
        flg <= 6'h06;
        far.press();
        repeat (4) @(posedge core_clk);
        chk(gerr_n, 1'b0);
        chk(gate, `GATE_BLOCKED);
        apb(1'b0, `REG_LIVE, 32'h00000000);
        chk(rd, 32'h00000186);
        flg <= 6'h00;
        apb(1'b1, `REG_CTRL, 32'h00000002);
        repeat (4) @(posedge core_clk);
        chk(gerr_n, 1'b1);
    endtask
    task t_regs();
        chk(irq, 1'b0);
        apb(1'b0, `REG_STATUS, 32'h00000000);
        chk(rd, 32'h0000003F);
        apb(1'b1, `REG_MASK, 32'h00000001);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b1);
        apb(1'b1, `REG_STATUS, 32'h00000001);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b0);
        apb(1'b0, `REG_LIMITS, 32'h00000000);
        chk(rd, 32'h375AA419);
        apb(1'b0, 8'h18, 32'h00000000);
        chk(serr, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        t_pass();
        t_decode();
        t_fault();
        t_refuse();
        t_regs();
        results();
    end
endmodule
